/* File: src/sctc_pkg.sv */
package sctc_pkg;

    typedef logic [15:0] sctc_data_t;

    // Sampling clock divide choices, in field order
    typedef enum logic [1:0] {
        sctc_div1,
        sctc_div2,
        sctc_div4,
        sctc_div_rsvd
    } sctc_div_e;

    // Main control register layout
    typedef struct packed {
        logic [5:0] rsvd_hi;
        sctc_div_e sampling_clock_divide;
        logic reload_buffer_enable;
        logic [3:0] rsvd_lo;
        logic update_request_source;
        logic update_inhibit;
        logic counter_run_enable;
    } sctc_ctrl_s;

    // Avalon-MM request as seen by the slave
    typedef struct packed {
        logic [6:0] address;
        logic read;
        logic write;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } sctc_avreq_s;

endpackage : sctc_pkg

/* File: src/sctc_prescaler.sv */
`timescale 1ns/10ps
`default_nettype none
module sctc_prescaler #(
    parameter int CNT_W = 16
) (
    input wire logic mclk,                // Timer clock
    input wire logic reset,               // Async reset, high
    input wire logic clear,               // Restart the division
    input wire logic [CNT_W-1:0] ratio,   // Divide by ratio plus one
    output logic tick                     // One pulse per counter clock
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic wrap;

    generate
        if (CNT_W < 1 || CNT_W > 32) begin : g_chk
            $error("sctc_prescaler: CNT_W out of range");
        end
    endgenerate

    // Wrap after ratio plus one input cycles
    assign wrap = (cnt_r >= ratio);
    assign cnt_nxt = wrap ? '0 : cnt_r + 1'b1;

    // Clear drops the count but keeps the ratio
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else begin
            cnt_r <= clear ? '0 : cnt_nxt;
            tick <= ~clear & wrap;
        end
    end
endmodule : sctc_prescaler
`default_nettype wire

/* File: src/sctc_regs.svh */
`ifndef SCTC_REGS_SVH
`define SCTC_REGS_SVH

// Byte offsets of the register map
`define SCTC_OFS_CTRL 7'h00
`define SCTC_OFS_IEN 7'h0c
`define SCTC_OFS_STS 7'h10
`define SCTC_OFS_EGEN 7'h14
`define SCTC_OFS_CMODE 7'h18
`define SCTC_OFS_CEN 7'h20
`define SCTC_OFS_CNT 7'h24
`define SCTC_OFS_PSC 7'h28
`define SCTC_OFS_RLD 7'h2c
`define SCTC_OFS_CC1 7'h34
`define SCTC_OFS_OPT 7'h50

// Field positions
`define SCTC_BIT_UPD 0
`define SCTC_BIT_CMP 1
`define SCTC_BIT_FORCE 0
`define SCTC_BIT_CC1_BUF 3

// Writable bits and reset values
`define SCTC_CTRL_WMASK 16'h0387
`define SCTC_IEN_WMASK 16'h0003
`define SCTC_CTRL_RST 16'h0000
`define SCTC_RLD_RST 16'hffff
`define SCTC_REG_RST 16'h0000

// Sampling divider terminal counts
`define SCTC_DIV1_LAST 2'h0
`define SCTC_DIV2_LAST 2'h1
`define SCTC_DIV4_LAST 2'h3

`endif

/* File: src/sctc_sample_div.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sctc_regs.svh"
module sctc_sample_div (
    input wire logic mclk,                    // Timer clock
    input wire logic reset,                   // Async reset, high
    input wire sctc_pkg::sctc_div_e divide,   // Sampling divide choice
    output logic sample_tick                  // One pulse per sampling period
);
    import sctc_pkg::*;

    logic [1:0] cnt_r;
    logic [1:0] last;
    logic wrap;

    // Reserved code behaves as divide by one
    assign last = (divide == sctc_div2) ? `SCTC_DIV2_LAST :
                  (divide == sctc_div4) ? `SCTC_DIV4_LAST : `SCTC_DIV1_LAST;
    assign wrap = (cnt_r >= last);

    // Free running period counter
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_r <= 2'h0;
            sample_tick <= 1'b0;
        end else begin
            cnt_r <= wrap ? 2'h0 : cnt_r + 2'h1;
            sample_tick <= wrap;
        end
    end
endmodule : sctc_sample_div
`default_nettype wire

/* File: src/sctc_top.sv */
// What this block does
// - Counter counts only while run enable is set; trigger input may set it.
// - Update event on overrun or force update, unless update inhibit is set.
// - Each update event copies buffered reload, prescale and compare into active.
// - Source bit 1 lets only overrun raise the update request and flag.
// - Reload write is immediate unless reload buffering is on.
// - Sampling period is one, two or four clocks; code 11 reserved.
// - Registers are 16 bits at their fixed offsets; option only if enabled.
// - Control register resets to zero.
// - Counter clock is timer clock over prescale value plus one.
// - Force update reinitialises counter, clears prescaler count, reads back zero.
// - Update request sets the sticky update flag until software clears it.
`timescale 1ns/10ps
`default_nettype none
`include "sctc_regs.svh"
module sctc_top #(
    parameter int CNT_W = 16,
    parameter bit HAS_OPTION = 1'b1
) (
    input wire logic mclk,                          // Timer clock, 100 MHz
    input wire logic reset,                         // Async reset, high
    input wire logic [6:0] avs_address,             // Byte address
    input wire logic avs_read,                      // Read request
    input wire logic avs_write,                     // Write request
    input wire logic [3:0] avs_byteenable,          // Byte lanes
    input wire logic [31:0] avs_writedata,          // Write data
    output logic [31:0] avs_readdata,               // Read data
    output logic avs_waitrequest,                   // Low for one answer cycle
    input wire logic trigger_start,                 // Hardware start of the counter
    output logic irq,                               // Level interrupt
    output logic update_event,                      // One pulse per update event
    output logic sample_tick,                       // Sampling clock pulse
    output sctc_pkg::sctc_data_t count_out          // Counter value
);
    import sctc_pkg::*;

    generate
        if (CNT_W != 16) begin : g_chk
            $error("sctc_top: only a 16-bit counter is supported");
        end
    endgenerate

    // Byte lane merge of a 16-bit register
    function automatic sctc_data_t lane_merge(input sctc_data_t old,
                                              input logic [31:0] d,
                                              input logic [3:0] be);
        lane_merge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction : lane_merge

    sctc_avreq_s req;
    sctc_ctrl_s ctrl_r;
    sctc_data_t ien_r;
    sctc_data_t sts_r;
    sctc_data_t sts_nxt;
    sctc_data_t cmode_r;
    sctc_data_t cen_r;
    sctc_data_t cnt_r;
    sctc_data_t cnt_nxt;
    sctc_data_t psc_pre_r;
    sctc_data_t psc_act_r;
    sctc_data_t rld_pre_r;
    sctc_data_t rld_act_r;
    sctc_data_t cc1_pre_r;
    sctc_data_t cc1_act_r;
    sctc_data_t opt_r;
    sctc_data_t rd_data;
    logic [1:0] sts_set;
    logic acc;
    logic wr;
    logic rd;
    logic hit_ctrl;
    logic hit_ien;
    logic hit_sts;
    logic hit_egen;
    logic hit_cmode;
    logic hit_cen;
    logic hit_cnt;
    logic hit_psc;
    logic hit_rld;
    logic hit_cc1;
    logic hit_opt;
    logic force_upd;
    logic cnt_tick;
    logic counting;
    logic overrun;
    logic upd_ev;
    logic upd_req;
    logic cmp_hit;
    logic sts_rd_clr;
    sctc_data_t wr_val;

    assign req = '{address: avs_address, read: avs_read, write: avs_write,
                   byteenable: avs_byteenable, writedata: avs_writedata};

    // Access completes on the cycle waitrequest is low
    assign acc = (req.read | req.write) & ~avs_waitrequest;
    assign wr = acc & req.write;
    assign rd = acc & req.read;

    // Address decode; option register only on the instance that has it
    assign hit_ctrl = (req.address == `SCTC_OFS_CTRL);
    assign hit_ien = (req.address == `SCTC_OFS_IEN);
    assign hit_sts = (req.address == `SCTC_OFS_STS);
    assign hit_egen = (req.address == `SCTC_OFS_EGEN);
    assign hit_cmode = (req.address == `SCTC_OFS_CMODE);
    assign hit_cen = (req.address == `SCTC_OFS_CEN);
    assign hit_cnt = (req.address == `SCTC_OFS_CNT);
    assign hit_psc = (req.address == `SCTC_OFS_PSC);
    assign hit_rld = (req.address == `SCTC_OFS_RLD);
    assign hit_cc1 = (req.address == `SCTC_OFS_CC1);
    assign hit_opt = HAS_OPTION && (req.address == `SCTC_OFS_OPT);

    // Readback selection; unmapped addresses and write-only event register read zero
    assign rd_data = ({16{hit_ctrl}} & sctc_data_t'(ctrl_r))
                   | ({16{hit_ien}} & ien_r)
                   | ({16{hit_sts}} & sts_r)
                   | ({16{hit_cmode}} & cmode_r)
                   | ({16{hit_cen}} & cen_r)
                   | ({16{hit_cnt}} & cnt_r)
                   | ({16{hit_psc}} & psc_pre_r)
                   | ({16{hit_rld}} & rld_pre_r)
                   | ({16{hit_cc1}} & cc1_pre_r)
                   | ({16{hit_opt}} & opt_r);

    // Bus answer: one wait cycle, then one cycle with waitrequest low
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~((req.read | req.write) & avs_waitrequest);
            avs_readdata <= {16'h0000, rd_data};
        end
    end

    // Force update is a self-clearing command bit; it never stores
    assign force_upd = wr & hit_egen & req.byteenable[0]
                     & req.writedata[`SCTC_BIT_FORCE];

    // Counter clock from the prescaler, restarted on force update
    sctc_prescaler #(.CNT_W(CNT_W)) u_psc (
        .mclk(mclk),
        .reset(reset),
        .clear(force_upd),
        .ratio(psc_act_r),
        .tick(cnt_tick)
    );

    // Sampling clock for dead time and filters
    sctc_sample_div u_sdiv (
        .mclk(mclk),
        .reset(reset),
        .divide(ctrl_r.sampling_clock_divide),
        .sample_tick(sample_tick)
    );

    // Counting needs run enable and a non-empty reload value
    assign counting = cnt_tick & ctrl_r.counter_run_enable
                    & (rld_act_r != 16'h0000);
    assign overrun = counting & (cnt_r == rld_act_r);
    assign cmp_hit = counting & (cnt_r == cc1_act_r);

    // Update events and the qualified request
    assign upd_ev = ~ctrl_r.update_inhibit & (overrun | force_upd);
    assign upd_req = upd_ev & (overrun | ~ctrl_r.update_request_source);

    // Counter next value: software write, then reinit, then count
    always_comb begin
        if (wr & hit_cnt) begin
            cnt_nxt = lane_merge(cnt_r, req.writedata, req.byteenable);
        end else if (force_upd | overrun) begin
            cnt_nxt = 16'h0000;
        end else if (counting) begin
            cnt_nxt = cnt_r + 16'h0001;
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    // Status flags: read of status or a written zero clears; set wins
    assign sts_set[`SCTC_BIT_UPD] = upd_req;
    assign sts_set[`SCTC_BIT_CMP] = cmp_hit;
    assign sts_rd_clr = rd & hit_sts;
    assign wr_val = lane_merge(16'hffff, req.writedata, req.byteenable);

    generate
        for (genvar i = 0; i < 2; i++) begin : g_sts
            assign sts_nxt[i] = sts_set[i]
                | (sts_r[i] & ~sts_rd_clr & ~(wr & hit_sts & ~wr_val[i]));
        end
    endgenerate
    assign sts_nxt[15:2] = 14'h0000;

    // Control register, reserved bits masked off
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctrl_r <= sctc_ctrl_s'(`SCTC_CTRL_RST);
        end else if (wr & hit_ctrl) begin
            ctrl_r <= sctc_ctrl_s'(lane_merge(sctc_data_t'(ctrl_r), req.writedata,
                      req.byteenable) & `SCTC_CTRL_WMASK);
        end else if (trigger_start) begin
            ctrl_r.counter_run_enable <= 1'b1;
        end
    end

    // Plain storage registers
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ien_r <= `SCTC_REG_RST;
            cmode_r <= `SCTC_REG_RST;
            cen_r <= `SCTC_REG_RST;
            opt_r <= `SCTC_REG_RST;
        end else begin
            if (wr & hit_ien) begin
                ien_r <= lane_merge(ien_r, req.writedata, req.byteenable)
                       & `SCTC_IEN_WMASK;
            end
            if (wr & hit_cmode) begin
                cmode_r <= lane_merge(cmode_r, req.writedata, req.byteenable);
            end
            if (wr & hit_cen) begin
                cen_r <= lane_merge(cen_r, req.writedata, req.byteenable);
            end
            if (wr & hit_opt) begin
                opt_r <= lane_merge(opt_r, req.writedata, req.byteenable);
            end
        end
    end

    // Buffered copies written by software
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            psc_pre_r <= `SCTC_REG_RST;
            rld_pre_r <= `SCTC_RLD_RST;
            cc1_pre_r <= `SCTC_REG_RST;
        end else begin
            if (wr & hit_psc) begin
                psc_pre_r <= lane_merge(psc_pre_r, req.writedata, req.byteenable);
            end
            if (wr & hit_rld) begin
                rld_pre_r <= lane_merge(rld_pre_r, req.writedata, req.byteenable);
            end
            if (wr & hit_cc1) begin
                cc1_pre_r <= lane_merge(cc1_pre_r, req.writedata, req.byteenable);
            end
        end
    end

    // Active copies: loaded on update, or at once when unbuffered
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            psc_act_r <= `SCTC_REG_RST;
            rld_act_r <= `SCTC_RLD_RST;
            cc1_act_r <= `SCTC_REG_RST;
        end else begin
            if (upd_ev) begin
                psc_act_r <= psc_pre_r;
                rld_act_r <= rld_pre_r;
                cc1_act_r <= cc1_pre_r;
            end
            if (wr & hit_rld & ~ctrl_r.reload_buffer_enable) begin
                rld_act_r <= lane_merge(rld_pre_r, req.writedata,
                                        req.byteenable);
            end
            if (wr & hit_cc1 & ~cmode_r[`SCTC_BIT_CC1_BUF]) begin
                cc1_act_r <= lane_merge(cc1_pre_r, req.writedata, req.byteenable);
            end
        end
    end

    // Counter, status, interrupt and event outputs
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_r <= `SCTC_REG_RST;
            sts_r <= `SCTC_REG_RST;
            irq <= 1'b0;
            update_event <= 1'b0;
            count_out <= `SCTC_REG_RST;
        end else begin
            cnt_r <= cnt_nxt;
            sts_r <= sts_nxt;
            irq <= |(sts_nxt & ien_r);
            update_event <= upd_ev;
            count_out <= cnt_nxt;
        end
    end
endmodule : sctc_top
`default_nettype wire

/* File: test/sctc_top_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module sctc_top_assertions (
    input wire logic mclk, // Timer clock
    input wire logic reset, // Async reset
    input wire logic [6:0] avs_address, // Byte address
    input wire logic avs_read, // Read
    input wire logic avs_write, // Write
    input wire logic [3:0] avs_byteenable, // Lanes
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [31:0] avs_readdata, // Read data
    input wire logic avs_waitrequest, // Wait
    input wire logic trigger_start, // Hardware start
    input wire logic irq, // Interrupt
    input wire logic update_event, // Update pulse
    input wire logic sample_tick, // Sampling pulse
    input wire sctc_pkg::sctc_data_t count_out // Counter
);
    import sctc_pkg::*;
    logic wr_acc;
    logic ctl_wr;
    logic frc;
    logic run_r;
    logic inh_r;
    logic [1:0] div_r;
    logic [1:0] chg_r;
    logic [2:0] gap_r;
    logic [2:0] gap_exp;
    // Decode completed writes of interest
    assign wr_acc = avs_write && !avs_waitrequest;
    assign ctl_wr = wr_acc && avs_address == 7'h00 && avs_byteenable[1:0] == 2'h3;
    assign frc = wr_acc && avs_address == 7'h14 && avs_byteenable[0] && avs_writedata[0];
    assign gap_exp = (div_r == 2'h2) ? 3'h3 : {2'h0, div_r == 2'h1};
    // Shadow of control fields and sampling tick spacing
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            run_r <= 1'b0;
            inh_r <= 1'b0;
            div_r <= 2'h0;
            chg_r <= 2'h2;
            gap_r <= 3'h0;
        end else begin
            run_r <= ctl_wr ? avs_writedata[0] : (run_r | trigger_start);
            inh_r <= ctl_wr ? avs_writedata[1] : inh_r;
            div_r <= ctl_wr ? avs_writedata[9:8] : div_r;
            chg_r <= (ctl_wr && avs_writedata[9:8] != div_r) ? 2'h2 :
                chg_r - {1'b0, sample_tick && chg_r != 2'h0};
            gap_r <= sample_tick ? 3'h0 : gap_r + 3'h1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    AST_WAIT_ONE: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    AST_WAIT_BACK: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_RD_HI: assert property (
        avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0)
        else $error("upper read half not zero");
    AST_CTRL_RSVD: assert property (
        avs_read && !avs_waitrequest && avs_address == 7'h00
        |-> (avs_readdata & 32'hfffffc78) == 32'h0)
        else $error("reserved control bits read nonzero");
    AST_FORCE_UEV: assert property (frc && !inh_r |=> update_event)
        else $error("force update gave no update event");
    AST_FORCE_CNT: assert property (frc |=> count_out == 16'h0)
        else $error("force update did not clear the counter");
    AST_INHIBIT: assert property (inh_r && $past(inh_r) |-> !update_event)
        else $error("update event while inhibited");
    AST_RUN_STOP: assert property (
        !$past(run_r) && !$past(wr_acc) |-> $stable(count_out))
        else $error("counter moved while stopped");
    AST_SAMPLE: assert property (sample_tick && chg_r == 2'h0 |-> gap_r == gap_exp)
        else $error("sampling tick spacing wrong");
endmodule : sctc_top_assertions
bind sctc_top sctc_top_assertions u_chk (.mclk(mclk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .trigger_start(trigger_start), .irq(irq),
    .update_event(update_event), .sample_tick(sample_tick), .count_out(count_out));
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sctc_regs.svh"
module tb_top;
    import sctc_pkg::*;
    logic mclk;
    logic reset;
    logic [6:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic trigger_start;
    logic irq;
    logic update_event;
    logic sample_tick;
    sctc_data_t count_out;
    int error_cnt = 0;
    int checks = 0;
    logic [31:0] seed = 32'h1132;
    logic [31:0] exp_q[$];
    logic irq_q[$];
    logic [15:0] v;
    int n;
    sctc_top dut (.mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .trigger_start(trigger_start), .irq(irq), .update_event(update_event),
        .sample_tick(sample_tick), .count_out(count_out));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // One Avalon-MM transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [6:0] a, input logic [15:0] d);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {16'h0, d};
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) @(posedge mclk);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask : bus
    task automatic rd(input logic [6:0] a, input logic [15:0] e, input logic ei);
        exp_q.push_back({16'h0, e});
        irq_q.push_back(ei);
        bus(1'b0, a, 16'h0);
    endtask : rd
    task automatic run_burst(input logic [15:0] c);
        bus(1'b1, `SCTC_OFS_CTRL, c | 16'h1);
        bus(1'b1, `SCTC_OFS_CTRL, c);
    endtask : run_burst
    // Cycles between counter steps must be prescale value plus one
    task automatic gap(input logic [15:0] p);
        logic [15:0] c;
        int g;
        bus(1'b1, `SCTC_OFS_PSC, p);
        bus(1'b1, `SCTC_OFS_EGEN, 16'h1);
        bus(1'b1, `SCTC_OFS_CTRL, 16'h1);
        c = count_out;
        while (count_out === c) @(posedge mclk);
        c = count_out;
        g = 0;
        while (count_out === c) begin
            @(posedge mclk);
            g++;
        end
        check(32'(g), 32'(p) + 32'h1);
        bus(1'b1, `SCTC_OFS_CTRL, 16'h0);
        rd(`SCTC_OFS_STS, 16'h1, 1'b0);
    endtask : gap
    // Read results are compared with the oldest note
    always @(posedge mclk) begin
        if (avs_read && !avs_waitrequest) begin
            check(avs_readdata, exp_q.pop_front());
            check({31'h0, irq}, {31'h0, irq_q.pop_front()});
        end
    end
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        summarize();
    end
    // Main sequence
    initial begin
        reset = 1'b1;
        avs_address = 7'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_byteenable = 4'hf;
        avs_writedata = 32'h0;
        trigger_start = 1'b0;
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        rd(`SCTC_OFS_CTRL, 16'h0, 1'b0);
        rd(`SCTC_OFS_RLD, 16'hffff, 1'b0);
        rd(`SCTC_OFS_PSC, 16'h0, 1'b0);
        bus(1'b1, 7'h04, 16'h1234);
        rd(7'h04, 16'h0, 1'b0);
        rd(7'h02, 16'h0, 1'b0);
        for (n = 0; n < 3; n++) begin
            v = xs() & 16'hfffe;
            bus(1'b1, `SCTC_OFS_CTRL, v);
            rd(`SCTC_OFS_CTRL, v & 16'h0387, 1'b0);
        end
        bus(1'b1, `SCTC_OFS_CTRL, 16'h0);
        bus(1'b1, `SCTC_OFS_CC1, 16'h8000);
        bus(1'b1, `SCTC_OFS_IEN, 16'h1);
        bus(1'b1, `SCTC_OFS_EGEN, 16'h1);
        rd(`SCTC_OFS_STS, 16'h1, 1'b1);
        rd(`SCTC_OFS_STS, 16'h0, 1'b0);
        bus(1'b1, `SCTC_OFS_IEN, 16'h0);
        bus(1'b1, `SCTC_OFS_EGEN, 16'h1);
        rd(`SCTC_OFS_STS, 16'h1, 1'b0);
        bus(1'b1, `SCTC_OFS_CTRL, 16'h2);
        bus(1'b1, `SCTC_OFS_CNT, 16'h5);
        bus(1'b1, `SCTC_OFS_EGEN, 16'h1);
        rd(`SCTC_OFS_CNT, 16'h0, 1'b0);
        rd(`SCTC_OFS_STS, 16'h0, 1'b0);
        bus(1'b1, `SCTC_OFS_CTRL, 16'h4);
        bus(1'b1, `SCTC_OFS_EGEN, 16'h1);
        rd(`SCTC_OFS_STS, 16'h0, 1'b0);
        rd(`SCTC_OFS_EGEN, 16'h0, 1'b0);
        bus(1'b1, `SCTC_OFS_CTRL, 16'h84);
        bus(1'b1, `SCTC_OFS_RLD, 16'h2);
        rd(`SCTC_OFS_RLD, 16'h2, 1'b0);
        bus(1'b1, `SCTC_OFS_CNT, 16'h2);
        run_burst(16'h84);
        rd(`SCTC_OFS_STS, 16'h0, 1'b0);
        bus(1'b1, `SCTC_OFS_EGEN, 16'h1);
        bus(1'b1, `SCTC_OFS_CNT, 16'h2);
        run_burst(16'h84);
        rd(`SCTC_OFS_STS, 16'h1, 1'b0);
        bus(1'b1, `SCTC_OFS_CTRL, 16'h4);
        bus(1'b1, `SCTC_OFS_RLD, 16'h3);
        bus(1'b1, `SCTC_OFS_CNT, 16'h3);
        run_burst(16'h4);
        rd(`SCTC_OFS_STS, 16'h1, 1'b0);
        // Compare flag and its mask, then buffered compare moved by an update
        bus(1'b1, `SCTC_OFS_IEN, 16'h2);
        bus(1'b1, `SCTC_OFS_CC1, 16'h1);
        bus(1'b1, `SCTC_OFS_CMODE, 16'h8);
        bus(1'b1, `SCTC_OFS_CC1, 16'h5);
        bus(1'b1, `SCTC_OFS_CNT, 16'h0);
        run_burst(16'h4);
        rd(`SCTC_OFS_STS, 16'h2, 1'b1);
        bus(1'b1, `SCTC_OFS_EGEN, 16'h1);
        bus(1'b1, `SCTC_OFS_CNT, 16'h4);
        run_burst(16'h4);
        rd(`SCTC_OFS_STS, 16'h2, 1'b1);
        bus(1'b1, `SCTC_OFS_CC1, 16'h8000);
        bus(1'b1, `SCTC_OFS_RLD, 16'hffff);
        bus(1'b1, `SCTC_OFS_CTRL, 16'h0);
        gap(16'h0);
        gap(xs() & 16'h7);
        gap(xs() & 16'h7);
        for (n = 0; n < 4; n++) begin
            bus(1'b1, `SCTC_OFS_CTRL, 16'(n) << 8);
            repeat (8) @(posedge mclk);
            v = 16'h0;
            repeat (16) begin
                @(posedge mclk);
                if (sample_tick === 1'b1) v++;
            end
            check({16'h0, v}, (n == 1) ? 32'h8 : (n == 2) ? 32'h4 : 32'h10);
        end
        bus(1'b1, `SCTC_OFS_CTRL, 16'h0);
        trigger_start <= 1'b1;
        @(posedge mclk);
        trigger_start <= 1'b0;
        @(posedge mclk);
        rd(`SCTC_OFS_CTRL, 16'h1, 1'b0);
        bus(1'b1, `SCTC_OFS_CTRL, 16'h0);
        repeat (4) @(posedge mclk);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
